// file: src/sbs_port.sv
// Synchronous port of a separate-I/O, two-word burst, double-data-rate SRAM.
// Assumes core_clk_i ticks once per rising edge of the input clock pair, so
// consecutive ticks alternate between the true and complement edge; the host
// drives all inputs synchronously to core_clk_i.
`timescale 1ns/100ps
`include "sbs_consts.svh"

// Summary of operation
// - Low load strobe on K edge starts transaction.
// - Each transaction moves exactly two words.
// - Read/write select high reads, low writes.
// - Address sampled on K rising edge only.
// - Nineteen address bits, each selecting a word pair.
// - Address ignored when port not selected.
// - Write words taken on K and complement edges.
// - Byte selects, active low, travel with words.
// - Unselected byte lanes keep their contents.
// - Read words driven on consecutive output edges.
// - Single clock mode drives from input clocks.
// - Read bus released when no read word.
// - Free-running echo clocks aligned to read data.
// - Reads and writes share address, both loaded on K edges.
// - Burst words transfer sequentially, word zero first.
// - Low DLL disable selects older one-cycle mode.
module sbs_port (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  input  wire sbs_pkg::sbs_cmd_t        cmd_i,
  input  wire sbs_pkg::sbs_wr_t         wr_i,
  input  wire logic                     dll_disable_n_i,
  input  wire logic                     single_clk_mode_i,
  output logic [`SBS_DATA_W-1:0]        rdata_o,
  output logic                          rdata_oe_n_o,
  output logic                          echo_clk_o,
  output logic                          echo_clk_n_o
);

  sbs_pkg::sbs_state_t st;
  sbs_pkg::sbs_state_t next_st;

  // Array of word pairs; kept outside the state struct because of its size.
  logic [`SBS_DATA_W-1:0] mem [0:(1<<`SBS_WORD_IDX_W)-1];

  logic                          k_edge;
  logic                          rd_take;
  logic                          wr_take;
  logic [`SBS_PIPE_D-1:0]        rd_v_w0;
  logic [`SBS_PIPE_D-1:0]        rd_v_w1;
  logic                          wr_now;
  logic [`SBS_WORD_IDX_W-1:0]    wr_idx;

  // Word pairs sit side by side in the array: the load address picks the pair
  // and the low index bit picks the burst word.
  function automatic logic [`SBS_WORD_IDX_W-1:0] word_index(
    input logic [`SBS_ADDR_W-1:0] addr,
    input logic                   second
  );
    word_index = {addr, second};
  endfunction : word_index

  assign k_edge  = (st.phase == `SBS_PHASE_K);
  assign rd_take = k_edge && !cmd_i.ld_n && cmd_i.rd_nwr;
  assign wr_take = k_edge && !cmd_i.ld_n && !cmd_i.rd_nwr;
  assign wr_now  = (st.wr_st != sbs_pkg::SBS_WR_IDLE);
  assign wr_idx  = word_index(st.wr_addr, st.wr_st == sbs_pkg::SBS_WR_WORD1);

  always_comb begin
    next_st          = st;
    next_st.phase    = ~st.phase;
    // The disable pin is a static strap from the board, hence two flops.
    next_st.dll_meta = dll_disable_n_i;
    next_st.dll_off  = ~st.dll_meta;
    next_st.echo     = next_st.phase;
    // Read requests age one edge per tick; the tap depends on the DLL mode.
    // A request taken on edge c0 sits in pipe bit 0 after that edge. With the
    // loop running, word zero is registered on edge c3 from bit 2 and word one
    // on c4 from bit 3; with it off, both move one edge earlier. The address
    // pipe shifts on every tick, so each tap holds the address that was loaded
    // together with the request in the same stage.
    next_st.pipe_v   = {st.pipe_v[`SBS_PIPE_D-2:0], rd_take};
    next_st.pipe_a   = {st.pipe_a[`SBS_PIPE_D-2:0], cmd_i.addr};
    if (st.dll_off) begin
      rd_v_w0 = 4'h2;
      rd_v_w1 = 4'h4;
    end else begin
      rd_v_w0 = 4'h4;
      rd_v_w1 = 4'h8;
    end
    next_st.rdata_oe_n = 1'h1;
    if (|(st.pipe_v & rd_v_w0)) begin
      next_st.rdata_oe_n = 1'h0;
      next_st.rdata = st.dll_off ? mem[word_index(st.pipe_a[1], 1'h0)]
                                 : mem[word_index(st.pipe_a[2], 1'h0)];
    end else if (|(st.pipe_v & rd_v_w1)) begin
      next_st.rdata_oe_n = 1'h0;
      next_st.rdata = st.dll_off ? mem[word_index(st.pipe_a[2], 1'h1)]
                                 : mem[word_index(st.pipe_a[3], 1'h1)];
    end
    case (st.wr_st)
      sbs_pkg::SBS_WR_IDLE: begin
        if (wr_take) begin
          next_st.wr_st   = sbs_pkg::SBS_WR_WORD0;
          next_st.wr_addr = cmd_i.addr;
        end
      end
      sbs_pkg::SBS_WR_WORD0: begin
        next_st.wr_st = sbs_pkg::SBS_WR_WORD1;
      end
      sbs_pkg::SBS_WR_WORD1: begin
        // A write loaded on this K edge overlaps the last word cleanly.
        if (wr_take) begin
          next_st.wr_st   = sbs_pkg::SBS_WR_WORD0;
          next_st.wr_addr = cmd_i.addr;
        end else begin
          next_st.wr_st = sbs_pkg::SBS_WR_IDLE;
        end
      end
      default: begin
        next_st.wr_st = sbs_pkg::SBS_WR_IDLE;
      end
    endcase
    // Reset releases the read bus and parks the strap at its enabled level,
    // so the first ticks after reset run with the longer latency.
    if (rst_i) begin
      next_st            = '0;
      next_st.rdata_oe_n = 1'h1;
      next_st.dll_meta   = 1'h1;
      next_st.wr_st      = sbs_pkg::SBS_WR_IDLE;
    end
  end

  always_ff @(posedge core_clk_i) begin
    st <= next_st;
  end

  // Write words land one per edge; lanes with a high select are untouched.
  // The array is not reset, so a read of a never-written pair gives unknowns.
  // The write needs no handshake: it completes on the edge that samples it.
  always_ff @(posedge core_clk_i) begin
    if (!rst_i && wr_now) begin
      for (int i = 0; i < `SBS_LANES; i++) begin
        if (!wr_i.bws_n[i]) begin
          mem[wr_idx][i*`SBS_LANE_W +: `SBS_LANE_W] <=
            wr_i.data[i*`SBS_LANE_W +: `SBS_LANE_W];
        end
      end
    end
  end

  // In this single-clock model the output clocks coincide with the input
  // clocks, so single clock mode changes nothing visible at these ports.
  assign rdata_o      = st.rdata;
  assign rdata_oe_n_o = st.rdata_oe_n;
  assign echo_clk_o   = st.echo;
  assign echo_clk_n_o = ~st.echo;

  // All checks share the one core clock and are silenced during reset; checks
  // that look back across the release guard themselves with the past value of
  // the reset.
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence rd_word_pair;
    !rdata_oe_n_o [*2];
  endsequence

  sequence wr_two_words;
    (st.wr_st == sbs_pkg::SBS_WR_WORD0) ##1 (st.wr_st == sbs_pkg::SBS_WR_WORD1);
  endsequence

  rd_lat_on_a: assert property (
    (rd_take && !st.dll_off && $stable(st.dll_off)) |-> ##4 rd_word_pair)
    else $error("read data not driven three edges after request");

  rd_lat_off_a: assert property (
    (rd_take && st.dll_off) |-> ##3 rd_word_pair)
    else $error("read data not driven two edges after request in DLL off mode");

  rd_release_a: assert property (
    (st.pipe_v == 4'h0) |=> rdata_oe_n_o)
    else $error("read bus driven with no read pending");

  echo_toggle_a: assert property (
    (echo_clk_n_o == !echo_clk_o) && ($past(rst_i) || (echo_clk_o != $past(echo_clk_o))))
    else $error("echo clocks not free running and complementary");

  wr_burst_a: assert property (
    wr_take |=> wr_two_words)
    else $error("write burst did not take exactly two words");

  odd_edge_a: assert property (
    (!k_edge && !cmd_i.ld_n) |=> !st.pipe_v[0])
    else $error("command taken on complement edge");

  idle_addr_a: assert property (
    (cmd_i.ld_n && !wr_now) |=> (!st.pipe_v[0] && !wr_now))
    else $error("unselected cycle started a transaction");

  rd_addr_a: assert property (
    rd_take |=> (st.pipe_a[0] == $past(cmd_i.addr)))
    else $error("read address not captured on load");

  // Lane checks read the array through sampled values. A lane that was never
  // written holds unknowns, so the kept-lane checks only hold once a location
  // has been filled; selects are narrowed only on such locations.
  sequence bus_released;
    rdata_oe_n_o [*2];
  endsequence

  sequence wr_last_word;
    (st.wr_st == sbs_pkg::SBS_WR_WORD1) ##1 (st.wr_st != sbs_pkg::SBS_WR_WORD1);
  endsequence

  lane0_keep_a: assert property (
    (wr_now && wr_i.bws_n[0])
    |=> (mem[$past(wr_idx)][`SBS_LANE_W-1:0] == $past(mem[wr_idx][`SBS_LANE_W-1:0])))
    else $error("unselected low byte lane changed on write");

  lane1_keep_a: assert property (
    (wr_now && wr_i.bws_n[1])
    |=> (mem[$past(wr_idx)][`SBS_DATA_W-1:`SBS_LANE_W] == $past(mem[wr_idx][`SBS_DATA_W-1:`SBS_LANE_W])))
    else $error("unselected high byte lane changed on write");

  lane0_write_a: assert property (
    (wr_now && !wr_i.bws_n[0])
    |=> (mem[$past(wr_idx)][`SBS_LANE_W-1:0] == $past(wr_i.data[`SBS_LANE_W-1:0])))
    else $error("selected low byte lane not written");

  lane1_write_a: assert property (
    (wr_now && !wr_i.bws_n[1])
    |=> (mem[$past(wr_idx)][`SBS_DATA_W-1:`SBS_LANE_W] == $past(wr_i.data[`SBS_DATA_W-1:`SBS_LANE_W])))
    else $error("selected high byte lane not written");

  // Write bookkeeping: the loaded address must stay put for both words, and a
  // burst never runs past its second word.
  wr_addr_take_a: assert property (
    wr_take |=> (st.wr_addr == $past(cmd_i.addr)))
    else $error("write address not captured on load");

  wr_addr_hold_a: assert property (
    (st.wr_st == sbs_pkg::SBS_WR_WORD0) |=> $stable(st.wr_addr))
    else $error("write address moved inside a burst");

  wr_last_a: assert property (
    (st.wr_st == sbs_pkg::SBS_WR_WORD0) |=> wr_last_word)
    else $error("write burst ran past its second word");

  wr_kbar_a: assert property (
    (!k_edge && !wr_now && !cmd_i.ld_n) |=> !wr_now)
    else $error("write started on complement edge");

  wr_phase_a: assert property (
    (st.wr_st == sbs_pkg::SBS_WR_WORD0) |-> !k_edge)
    else $error("first write word not on complement edge");

  wr_state_a: assert property (
    st.wr_st inside {sbs_pkg::SBS_WR_IDLE, sbs_pkg::SBS_WR_WORD0, sbs_pkg::SBS_WR_WORD1})
    else $error("write state out of range");

  wr_not_rd_a: assert property (
    (k_edge && !cmd_i.ld_n && !cmd_i.rd_nwr) |=> !st.pipe_v[0])
    else $error("write command loaded a read");

  rd_not_wr_a: assert property (
    (k_edge && !cmd_i.ld_n && cmd_i.rd_nwr && !wr_now) |=> !wr_now)
    else $error("read command started a write");

  wr_kbar_word_a: assert property (
    !k_edge |=> (st.wr_st != sbs_pkg::SBS_WR_WORD0))
    else $error("write loaded on complement edge");

  // Read side: the bus is only driven for a pending request and the data
  // register holds still between bursts.
  rd_quiet_a: assert property (
    ((st.pipe_v == 4'h0) && !rd_take) |=> bus_released)
    else $error("read bus driven with no request");

  rdata_hold_a: assert property (
    ((st.pipe_v & (rd_v_w0 | rd_v_w1)) == 4'h0)
    |=> $stable(rdata_o))
    else $error("read data changed with no word due");

  oe_needs_req_a: assert property (
    !rdata_oe_n_o |-> ($past(st.pipe_v) != 4'h0))
    else $error("read bus driven without a queued request");

  rd_pipe_a: assert property (
    rd_take |=> st.pipe_v[0])
    else $error("read request not queued");

  // The strap reaches the latency select two ticks after the pin.
  dll_sync_a: assert property (
    (!$past(rst_i) && !$past(rst_i, 2))
    |-> (st.dll_off == !$past(dll_disable_n_i, 2)))
    else $error("DLL disable strap not synchronised");

  echo_phase_a: assert property (
    echo_clk_o == st.phase)
    else $error("echo clock not aligned to edge phase");

endmodule : sbs_port

// file: shared/sbs_consts.svh
// Timing counts, widths, clock rates and phase codes of the burst SRAM port.
// Assumes it is included by bare name from files that need these values.
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH

`define SBS_ADDR_W        19
`define SBS_DATA_W        18
`define SBS_LANES         2
`define SBS_LANE_W        9
`define SBS_WORD_IDX_W    20
`define SBS_PIPE_D        4
`define SBS_LAT_DLL_ON    3
`define SBS_LAT_DLL_OFF   2
`define SBS_DLL_OFF_MHZ   167
`define SBS_CLK_MHZ       125
`define SBS_PHASE_K       1'h0
`define SBS_PHASE_KN      1'h1

`endif

// file: shared/sbs_pkg.sv
// Types shared by the burst SRAM port and its environment.
// Assumes sbs_consts.svh is on the include path.
`include "sbs_consts.svh"

package sbs_pkg;

  typedef struct packed {
    logic                    ld_n;
    logic                    rd_nwr;
    logic [`SBS_ADDR_W-1:0]  addr;
  } sbs_cmd_t;

  typedef struct packed {
    logic [`SBS_DATA_W-1:0]  data;
    logic [`SBS_LANES-1:0]   bws_n;
  } sbs_wr_t;

  typedef enum logic [1:0] {
    SBS_WR_IDLE  = 2'h0,
    SBS_WR_WORD0 = 2'h1,
    SBS_WR_WORD1 = 2'h2
  } sbs_wr_st_t;

  typedef struct packed {
    logic                                    phase;
    logic                                    dll_meta;
    logic                                    dll_off;
    logic [`SBS_PIPE_D-1:0]                  pipe_v;
    logic [`SBS_PIPE_D-1:0][`SBS_ADDR_W-1:0] pipe_a;
    sbs_wr_st_t                              wr_st;
    logic [`SBS_ADDR_W-1:0]                  wr_addr;
    logic [`SBS_DATA_W-1:0]                  rdata;
    logic                                    rdata_oe_n;
    logic                                    echo;
  } sbs_state_t;

endpackage : sbs_pkg

// file: tb/sbs_host.sv
// Host controller model that issues commands and write words to the port.
// Assumes one bench process calls issue at a time.
`timescale 1ns/100ps
`include "sbs_consts.svh"
module sbs_host (
  input  wire logic         core_clk_i,
  input  wire logic         echo_clk_i,
  output sbs_pkg::sbs_cmd_t cmd_o,
  output sbs_pkg::sbs_wr_t  wr_o
);
  initial begin
    cmd_o = {1'h1, 1'h1, 19'h0};
    wr_o  = '0;
  end
  // Released address and write lines toggle so that a design which samples them is caught.
  task automatic idle();
    cmd_o.ld_n = 1'h1;
    cmd_o.addr = ~cmd_o.addr;
    wr_o       = ~wr_o;
  endtask : idle
  task automatic issue(input logic rd, input logic kbar, input logic [`SBS_ADDR_W-1:0] a,
                       input sbs_pkg::sbs_wr_t w0, input sbs_pkg::sbs_wr_t w1);
    do @(posedge core_clk_i) #1; while (echo_clk_i !== kbar);
    cmd_o = {1'h0, rd, a};
    @(posedge core_clk_i) #1;
    idle();
    if (!rd && !kbar) begin
      wr_o = w0;
      @(posedge core_clk_i) #1;
      wr_o = w1;
      @(posedge core_clk_i) #1;
      idle();
    end
  endtask : issue
endmodule : sbs_host

// file: tb/sbs_port_tb.sv
// Self-checking bench for the burst SRAM port with an associative-array memory model.
// Assumes the host model in sbs_host.sv and the shared package.
`timescale 1ns/100ps
`include "sbs_consts.svh"
module sbs_port_tb;
  logic core_clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic dll_n = 1'h1;
  logic sclk = 1'h0;
  sbs_pkg::sbs_cmd_t cmd;
  sbs_pkg::sbs_wr_t  wr;
  logic [17:0] rdata;
  logic oe_n, echo, echo_n, last_echo, was_run = 1'h0;
  int n_mismatch = 0, n_compared = 0, tick = 0, lat = 3;
  logic [17:0] mem [int];
  int exp_t[$];
  logic [17:0] exp_d[$], a[8];
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) tick <= tick + 1;
  sbs_port u_sbs_port (.core_clk_i(core_clk_i), .rst_i(rst_i), .cmd_i(cmd), .wr_i(wr),
    .dll_disable_n_i(dll_n), .single_clk_mode_i(sclk), .rdata_o(rdata),
    .rdata_oe_n_o(oe_n), .echo_clk_o(echo), .echo_clk_n_o(echo_n));
  sbs_host u_sbs_host (.core_clk_i(core_clk_i), .echo_clk_i(echo), .cmd_o(cmd), .wr_o(wr));
  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  always @(posedge core_clk_i) begin
    #2;
    if (rst_i) chk({17'h0, oe_n}, 18'h1, "bus driven in reset");
    if (!rst_i && was_run) begin
      chk({echo, echo_n}, {~last_echo, last_echo}, "echo pair");
      while (exp_t.size() > 0 && exp_t[0] < tick) begin
        chk(18'(exp_t.pop_front()), 18'(tick), "read word missing");
        void'(exp_d.pop_front());
      end
      if (oe_n === 1'h0 && exp_t.size() == 0) chk({17'h0, oe_n}, 18'h1, "stray word");
      else if (oe_n === 1'h0) begin
        chk(18'(exp_t.pop_front()), 18'(tick), "read latency");
        chk(rdata, exp_d.pop_front(), "read data");
      end
    end
    was_run = !rst_i;
    last_echo = echo;
  end
  function automatic void upd(input int k, input logic [17:0] d, input logic [1:0] b);
    logic [17:0] m = mem.exists(k) ? mem[k] : 18'h0;
    if (!b[0]) m[8:0] = d[8:0];
    if (!b[1]) m[17:9] = d[17:9];
    mem[k] = m;
  endfunction : upd
  task automatic wrt(input logic [18:0] ad, input logic [1:0] b0, input logic [1:0] b1);
    logic [17:0] d0 = 18'($urandom);
    logic [17:0] d1 = 18'($urandom);
    u_sbs_host.issue(1'h0, 1'h0, ad, {d0, b0}, {d1, b1});
    upd(int'({ad, 1'h0}), d0, b0);
    upd(int'({ad, 1'h1}), d1, b1);
  endtask : wrt
  task automatic rd(input logic [18:0] ad);
    u_sbs_host.issue(1'h1, 1'h0, ad, '0, '0);
    exp_t.push_back(tick + lat);
    exp_t.push_back(tick + lat + 1);
    exp_d.push_back(mem[int'({ad, 1'h0})]);
    exp_d.push_back(mem[int'({ad, 1'h1})]);
  endtask : rd
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hC215));
    sclk = 1'($urandom);
    repeat (16) @(posedge core_clk_i);
    #1 rst_i = 1'h0;
    for (int i = 0; i < 8; i++) begin
      a[i] = 18'($urandom);
      wrt({a[i][17:0], i[0]}, 2'h0, 2'h0);
    end
    wrt(19'h7FFFF, 2'h0, 2'h0);
    for (int i = 0; i < 8; i++) rd({a[i][17:0], i[0]});
    rd(19'h7FFFF);
    wrt({a[0][17:0], 1'h0}, 2'h1, 2'h2);
    wrt({a[1][17:0], 1'h1}, 2'h3, 2'h3);
    u_sbs_host.issue(1'h1, 1'h1, 19'h0, '0, '0);
    rd({a[0][17:0], 1'h0});
    rd({a[1][17:0], 1'h1});
    repeat (8) @(posedge core_clk_i);
    #1 dll_n = 1'h0;
    lat = 2;
    repeat (4) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++) rd({a[i][17:0], i[0]});
    repeat (10) @(posedge core_clk_i);
    chk(18'(exp_t.size()), 18'h0, "reads outstanding");
    print_verdict();
  end
endmodule : sbs_port_tb
